// File: hdl/aes_block_cipher_accelerator.v
// AES accelerator top: APB registers, key handling, chaining modes, DMA and interrupt
// Notes on behaviour
// R1: Encrypt and decrypt per the standard AES cipher.
// R2: Key size 128 or 256 bits selects 10 or 14 rounds.
// R3: Modes ECB, CBC, CTR, GCM, GMAC, CCM selectable per message; GCM, GMAC and CCM run as plain CTR here.
// R4: Each cipher operation handles one 128-bit block.
// R5: ECB encryption finishes in 51 cycles (128-bit key) or 75 (256-bit).
// R6: Key registers are write-only; reads return zero.
// R7: Key becomes usable only once completely written, atomically.
// R8: Four 32-bit registers hold the IV or counter.
// R9: Decryption derives the last round key with an internal scheduler.
// R10: Blocks move as four 32-bit words through one input and one output buffer.
// R11: Separate DMA requests for input and output words.
// R12: Data swapping at 1, 8, 16 or 32-bit granularity.
// R13: Context (IV, key) can be saved and restored to suspend a message.
// R14: Completion flag set when output is ready, optional interrupt, software clear.
// R15: Writing input or reading output when not ready is ignored and flagged.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "aes_accel_defines.vh"

module aes_block_cipher_accelerator (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         irq,
  output reg         dma_in_req,
  output reg         dma_out_req
);

  localparam [1:0] IDLE = 2'h0;
  localparam [1:0] PREP = 2'h1;
  localparam [1:0] RUN  = 2'h2;
  localparam [1:0] WAIT = 2'h3;

  reg [`CTRL_W-1:0] ctrl;
  reg [2:0]         istat;
  reg [2:0]         ien;
  reg [255:0]       kshadow;
  reg [255:0]       key;
  reg [7:0]         kmask;
  reg               kval;
  reg [127:0]       iv;
  reg [127:0]       in_blk;
  reg [127:0]       out_blk;
  reg [2:0]         in_cnt;
  reg [1:0]         out_cnt;
  reg               out_pend;
  reg               rd_pop;
  reg               rd_bad;
  reg [1:0]         state;
  reg [127:0]       st;
  reg [255:0]       kw;
  reg [7:0]         rcon;
  reg               gph;
  reg [3:0]         rnd;
  reg [6:0]         cnt;

  function [31:0] swp(input [31:0] d, input [1:0] m);
    integer i;
    begin
      swp = d;
      case (m)
        `SW_16: swp = {d[15:0], d[31:16]};
        `SW_8:  swp = {d[7:0], d[15:8], d[23:16], d[31:24]};
        `SW_1: begin
          for (i = 0; i < 32; i = i + 1)
            swp[i] = d[31-i];
        end
        default: swp = d;
      endcase
    end
  endfunction

  function [7:0] xt(input [7:0] x);
    xt = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
  endfunction

  function [7:0] ixt(input [7:0] x);
    ixt = {x[0], x[7:1]} ^ (x[0] ? 8'h0D : 8'h00);
  endfunction

  wire       en       = ctrl[`C_EN];
  wire [2:0] mode     = ctrl[`C_MODE_HI:`C_MODE_LO];
  wire [1:0] swap     = ctrl[`C_SWAP_HI:`C_SWAP_LO];
  wire       k256     = ctrl[`C_K256];
  wire       is_cbc   = (mode == `M_CBC);
  // R3 counter family
  wire       ctr_like = (mode != `M_ECB) && !is_cbc;
  wire       dec      = ctrl[`C_DEC] & ~ctr_like;
  // R2 round count
  wire [3:0] nr       = k256 ? `NR256 : `NR128;
  wire [3:0] nstep    = k256 ? `STEP256 : `STEP128;
  // R5 fixed latency
  wire [6:0] lat2     = (k256 ? `LAT256 : `LAT128) - 7'h02;
  wire       busy     = (state != IDLE);
  wire       last     = (rnd == nr - 4'h1);
  wire       fin      = (state == WAIT) && (cnt == lat2);

  // Key schedule, run forward or backward one round key per cycle
  wire          bwd  = (state == RUN) & dec;
  wire          g    = ~k256 | (bwd ? ~gph : gph);
  wire [7:0]    rc   = bwd ? ixt(rcon) : rcon;
  wire [127:0]  nb   = k256 ? kw[127:0] : kw[255:128];
  wire [31:0]   r3   = nb[31:0] ^ nb[63:32];
  wire [31:0]   r2   = nb[63:32] ^ nb[95:64];
  wire [31:0]   r1   = nb[95:64] ^ nb[127:96];
  wire [31:0]   tin  = bwd ? (k256 ? kw[159:128] : r3) : (k256 ? kw[31:0] : kw[159:128]);
  wire [31:0]   tout;
  wire [31:0]   tk   = tout ^ (g ? {rc, 24'h000000} : 32'h00000000);
  wire [31:0]   f0   = kw[255:224] ^ tk;
  wire [31:0]   f1   = kw[223:192] ^ f0;
  wire [31:0]   f2   = kw[191:160] ^ f1;
  wire [31:0]   f3   = kw[159:128] ^ f2;
  wire [31:0]   r0   = nb[127:96] ^ tk;
  wire [255:0]  kfwd = k256 ? {kw[127:0], f0, f1, f2, f3} : {f0, f1, f2, f3, 128'h0};
  wire [255:0]  kbwd = k256 ? {r0, r1, r2, r3, kw[255:128]} : {r0, r1, r2, r3, 128'h0};
  wire [127:0]  rk   = bwd ? (k256 ? kw[255:128] : kbwd[255:128])
                           : (k256 ? kw[127:0] : kfwd[255:128]);
  wire [127:0]  rout;

  aes_round u_round (
    .st_in  (st),
    .rk     (rk),
    .inv    (dec),
    .last   (last),
    .tin    (tin),
    .rot    (g),
    .st_out (rout),
    .tout   (tout)
  );

  // APB decode
  wire setup   = psel & ~penable;
  wire done    = psel & penable & pready;
  wire wr      = done & pwrite;
  wire mapped  = (paddr[1:0] == 2'h0) && (paddr <= `A_IV3) &&
                 ((paddr >= `A_KEY0) || (paddr <= `A_IEN));
  wire key_reg = (paddr[7:5] == 3'h1);
  wire iv_reg  = (paddr[7:4] == 4'h4);
  wire in_ok   = en && !busy && !out_pend && (in_cnt != 3'h4);
  wire go      = en && !busy && !out_pend && (in_cnt == 3'h4) && kval;

  // R7 staged key words
  wire [2:0]   kidx       = paddr[4:2];
  wire [255:0] kwm        = {32'hFFFFFFFF, 224'h0} >> (32 * kidx);
  wire [255:0] next_kshad = (kshadow & ~kwm) | ({pwdata, 224'h0} >> (32 * kidx));
  wire [7:0]   next_kmask = ((kidx == 3'h0) ? 8'h00 : kmask) | (8'h01 << kidx);
  wire         key_full   = k256 ? (kidx == 3'h7 && next_kmask == 8'hFF)
                                 : (kidx == 3'h3 && next_kmask[3:0] == 4'hF);

  // R15 ignored accesses
  wire bad_wr  = ((paddr == `A_DIN) && !in_ok) ||
                 (((paddr == `A_CTRL) || iv_reg) && busy);
  wire set_wr  = wr && mapped && bad_wr;
  wire set_rd  = done && !pwrite && rd_bad;
  wire [2:0] clr = (wr && paddr == `A_ICLR) ? pwdata[2:0] : 3'h0;
  // R14 set wins over clear
  wire [2:0] next_istat = (istat & ~clr) | {set_wr, set_rd, fin};
  // R14 enable applies at once
  wire [2:0] next_ien   = (wr && mapped && paddr == `A_IEN) ? pwdata[2:0] : ien;

  // R3 chaining input and output
  wire [127:0] x   = ctr_like ? iv : ((is_cbc && !dec) ? (in_blk ^ iv) : in_blk);
  wire [127:0] res = ctr_like ? (st ^ in_blk) : ((is_cbc && dec) ? (st ^ iv) : st);
  wire [31:0]  out_word = out_blk[127-32*out_cnt -: 32];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      rd_pop  <= 1'b0;
      rd_bad  <= 1'b0;
    end else if (setup) begin
      pready  <= 1'b1;
      pslverr <= ~mapped;
      rd_pop  <= ~pwrite && (paddr == `A_DOUT) && out_pend;
      rd_bad  <= ~pwrite && (paddr == `A_DOUT) && !out_pend;
      // R6 keys never readable
      case (paddr)
        `A_CTRL:  prdata <= {22'h0, ctrl};
        `A_STAT:  prdata <= {28'h0, out_pend, in_ok, kval, busy};
        // R12 output swap
        `A_DOUT:  prdata <= out_pend ? swp(out_word, swap) : 32'h00000000;
        `A_ISTAT: prdata <= {29'h0, istat};
        `A_IEN:   prdata <= {29'h0, ien};
        default:  prdata <= (iv_reg && mapped) ? iv[127-32*paddr[3:2] -: 32] : 32'h00000000;
      endcase
    end else begin
      pready <= 1'b0;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= `CTRL_RST;
      istat       <= 3'h0;
      ien         <= 3'h0;
      kshadow     <= 256'h0;
      key         <= 256'h0;
      kmask       <= 8'h00;
      kval        <= 1'b0;
      iv          <= 128'h0;
      in_blk      <= 128'h0;
      out_blk     <= 128'h0;
      in_cnt      <= 3'h0;
      out_cnt     <= 2'h0;
      out_pend    <= 1'b0;
      irq         <= 1'b0;
      dma_in_req  <= 1'b0;
      dma_out_req <= 1'b0;
    end else begin
      istat <= next_istat;
      irq   <= |(next_istat & next_ien);
      // R11 input request drops with the fourth word
      dma_in_req <= ctrl[`C_DMAI] && in_ok &&
                    !(wr && paddr == `A_DIN && in_cnt == 3'h3);
      dma_out_req <= ctrl[`C_DMAO] &&
                     ((out_pend && !(done && rd_pop && out_cnt == 2'h3)) || fin);
      // Unaligned or unmapped writes must not alias onto key or IV words
      // Key words written while busy still commit once complete; the running block keeps its copy in kw
      if (wr && mapped && !bad_wr) begin
        if (paddr == `A_CTRL) begin
          ctrl <= pwdata[`CTRL_W-1:0];
          // Size change leaves the staged key meaningless
          if (pwdata[`C_K256] != k256)
            kval <= 1'b0;
          if (!pwdata[`C_EN]) begin
            in_cnt   <= 3'h0;
            out_pend <= 1'b0;
          end
        end
        if (paddr == `A_IEN)
          ien <= pwdata[2:0];
        // R10 R12 input word
        if (paddr == `A_DIN) begin
          in_blk[127-32*in_cnt -: 32] <= swp(pwdata, swap);
          in_cnt <= in_cnt + 3'h1;
        end
        // R13 IV restore
        if (iv_reg)
          iv[127-32*paddr[3:2] -: 32] <= pwdata;
        if (key_reg) begin
          kshadow <= next_kshad;
          kmask   <= next_kmask;
          // R7 atomic commit
          if (key_full) begin
            key  <= next_kshad;
            kval <= 1'b1;
          end
        end
      end
      // R10 output word drained
      if (done && !pwrite && rd_pop) begin
        out_cnt <= out_cnt + 2'h1;
        if (out_cnt == 2'h3)
          out_pend <= 1'b0;
      end
      if (go)
        in_cnt <= 3'h0;
      // R14 R8 block complete
      if (fin) begin
        out_blk  <= res;
        out_pend <= 1'b1;
        out_cnt  <= 2'h0;
        if (ctr_like)
          iv[31:0] <= iv[31:0] + 32'h00000001;
        else if (is_cbc)
          iv <= dec ? in_blk : st;
      end
    end
  end

  // Cipher sequencer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= IDLE;
      st    <= 128'h0;
      kw    <= 256'h0;
      rcon  <= `RCON0;
      gph   <= 1'b1;
      rnd   <= 4'h0;
      cnt   <= 7'h00;
    end else begin
      if (state == PREP || state == RUN) begin
        kw  <= bwd ? kbwd : kfwd;
        gph <= ~gph;
        if (g)
          rcon <= bwd ? rc : xt(rcon);
      end
      if (busy)
        cnt <= cnt + 7'h01;
      case (state)
        IDLE: begin
          if (go) begin
            kw    <= key;
            rcon  <= `RCON0;
            gph   <= 1'b1;
            rnd   <= 4'h0;
            cnt   <= 7'h00;
            // R4 one block per operation
            st    <= dec ? x : (x ^ key[255:128]);
            state <= dec ? PREP : RUN;
          end
        end
        PREP: begin
          rnd <= rnd + 4'h1;
          // R9 last round key reached
          if (rnd == nstep - 4'h1) begin
            st    <= st ^ (k256 ? kfwd[127:0] : kfwd[255:128]);
            rnd   <= 4'h0;
            state <= RUN;
          end
        end
        RUN: begin
          // R1 R2 one round per cycle
          st  <= rout;
          rnd <= rnd + 4'h1;
          if (last)
            state <= WAIT;
        end
        WAIT: begin
          // R5 pad to the fixed latency
          if (fin)
            state <= IDLE;
        end
        default: state <= IDLE;
      endcase
    end
  end

endmodule // aes_block_cipher_accelerator

`default_nettype wire

// File: hdl/aes_accel_defines.vh
// Register map, field positions, codes and cycle counts of the AES accelerator
`ifndef AES_ACCEL_DEFINES_VH
`define AES_ACCEL_DEFINES_VH

// Register byte offsets
`define A_CTRL    8'h00
`define A_STAT    8'h04
`define A_DIN     8'h08
`define A_DOUT    8'h0C
`define A_ISTAT   8'h10
`define A_ICLR    8'h14
`define A_IEN     8'h18
`define A_KEY0    8'h20
`define A_IV0     8'h40
`define A_IV3     8'h4C

// Control register fields
`define C_EN      0
`define C_DEC     1
`define C_MODE_LO 2
`define C_MODE_HI 4
`define C_SWAP_LO 5
`define C_SWAP_HI 6
`define C_K256    7
`define C_DMAI    8
`define C_DMAO    9
`define CTRL_W    10
`define CTRL_RST  10'h000

// Chaining modes
`define M_ECB     3'h0
`define M_CBC     3'h1
`define M_CTR     3'h2
`define M_GCM     3'h3
`define M_GMAC    3'h4
`define M_CCM     3'h5

// Swap granularity
`define SW_32     2'h0
`define SW_16     2'h1
`define SW_8      2'h2
`define SW_1      2'h3

// Interrupt status bits
`define I_CCF     0
`define I_RDERR   1
`define I_WRERR   2

// Rounds, key schedule steps, block latency (51 and 75 cycles)
`define NR128     4'hA
`define NR256     4'hE
`define STEP128   4'hA
`define STEP256   4'hD
`define LAT128    7'h33
`define LAT256    7'h4B
`define RCON0     8'h01

`endif

// File: hdl/aes_round.v
// One AES round (forward or inverse) plus the key schedule word substitution
`timescale 1ns/1ns
`default_nettype none

module aes_round (
  input  wire [127:0] st_in,
  input  wire [127:0] rk,
  input  wire         inv,
  input  wire         last,
  input  wire [31:0]  tin,
  input  wire         rot,
  output reg  [127:0] st_out,
  output reg  [31:0]  tout
);

  reg [7:0]  s [0:15];
  reg [7:0]  m [0:15];
  reg [7:0]  cf;
  reg [31:0] w;
  integer    k;
  integer    j;
  integer    r;
  integer    c;

  function [7:0] gmul(input [7:0] a, input [7:0] b);
    integer i;
    reg [7:0] p;
    reg [7:0] x;
    begin
      p = 8'h00;
      x = a;
      for (i = 0; i < 8; i = i + 1) begin
        if (b[i])
          p = p ^ x;
        x = {x[6:0], 1'b0} ^ (x[7] ? 8'h1B : 8'h00);
      end
      gmul = p;
    end
  endfunction

  // Field inverse as a^254; avoids a 256-entry table at the cost of depth
  function [7:0] ginv(input [7:0] a);
    integer i;
    reg [7:0] q;
    reg [7:0] p;
    begin
      q = 8'h01;
      p = a;
      for (i = 0; i < 7; i = i + 1) begin
        p = gmul(p, p);
        q = gmul(q, p);
      end
      ginv = q;
    end
  endfunction

  function [7:0] sbox(input [7:0] a);
    reg [7:0] b;
    begin
      b = ginv(a);
      sbox = b ^ {b[6:0], b[7]} ^ {b[5:0], b[7:6]} ^ {b[4:0], b[7:5]} ^ {b[3:0], b[7:4]} ^ 8'h63;
    end
  endfunction

  function [7:0] isbox(input [7:0] a);
    begin
      isbox = ginv({a[6:0], a[7]} ^ {a[4:0], a[7:5]} ^ {a[1:0], a[7:2]} ^ 8'h05);
    end
  endfunction

  // R1 round transforms
  always @* begin
    for (k = 0; k < 16; k = k + 1) begin
      r = k % 4;
      c = k / 4;
      if (inv)
        s[k] = isbox(st_in[127-8*(r+4*((c+4-r)%4)) -: 8]) ^ rk[127-8*k -: 8];
      else
        s[k] = sbox(st_in[127-8*(r+4*((c+r)%4)) -: 8]);
    end
    for (k = 0; k < 16; k = k + 1) begin
      r = k % 4;
      c = k / 4;
      m[k] = 8'h00;
      for (j = 0; j < 4; j = j + 1) begin
        case (j)
          0: cf = inv ? 8'h0E : 8'h02;
          1: cf = inv ? 8'h0B : 8'h03;
          2: cf = inv ? 8'h0D : 8'h01;
          default: cf = inv ? 8'h09 : 8'h01;
        endcase
        m[k] = m[k] ^ gmul(s[(r+j)%4 + 4*c], cf);
      end
      st_out[127-8*k -: 8] = (last ? s[k] : m[k]) ^ (inv ? 8'h00 : rk[127-8*k -: 8]);
    end
    w = rot ? {tin[23:0], tin[31:24]} : tin;
    tout = {sbox(w[31:24]), sbox(w[23:16]), sbox(w[15:8]), sbox(w[7:0])};
  end

endmodule // aes_round

`default_nettype wire

// File: tb/aes_accel_sva.sv
// Port-level assertion checker for the AES accelerator
`timescale 1ns/1ns
`default_nettype none
`include "aes_accel_defines.vh"
module aes_accel_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        dma_in_req,
  input wire logic        dma_out_req
);
  logic       blk;
  logic       k256;
  logic [1:0] nin;
  logic [1:0] nout;
  logic [2:0] ien;
  logic [6:0] age;
  wire logic acc = psel && penable && pready;
  wire logic wrd = acc && pwrite && paddr == `A_DIN && !blk;
  wire logic go  = wrd && nin == 2'h3;
  // Output words only count once the block latency has run out
  wire logic rdo = acc && !pwrite && paddr == `A_DOUT && blk && age >= (k256 ? `LAT256 : `LAT128);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blk  <= 1'b0;
      k256 <= 1'b0;
      nin  <= 2'h0;
      nout <= 2'h0;
      ien  <= 3'h0;
      age  <= 7'h0;
    end else begin
      if (acc && pwrite && paddr == `A_CTRL && !blk) k256 <= pwdata[`C_K256];
      if (acc && pwrite && paddr == `A_IEN) ien <= pwdata[2:0];
      if (wrd) nin <= nin + 2'h1;
      if (rdo) nout <= nout + 2'h1;
      if (go) blk <= 1'b1;
      else if (rdo && nout == 2'h3) blk <= 1'b0;
      if (go) age <= 7'h0;
      else if (age != 7'h7F) age <= age + 7'h1;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_go128; go && !k256 && ien == 3'h1 && !irq; endsequence
  sequence s_go256; go && k256 && ien == 3'h1 && !irq; endsequence
  sequence s_done128; ##51 !irq ##1 irq; endsequence
  sequence s_done256; ##75 !irq ##1 irq; endsequence

  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("pready missing in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (acc && paddr == 8'h1C |-> pslverr)
    else $error("unmapped access without slave error");
  a_key_hidden: assert property (acc && !pwrite && paddr >= `A_KEY0 && paddr < `A_IV0 |-> prdata == 32'h0)
    else $error("key register read returned data");
  a_lat_short: assert property (s_go128 |-> s_done128)
    else $error("128-bit block latency wrong");
  a_lat_long: assert property (s_go256 |-> s_done256)
    else $error("256-bit block latency wrong");
  a_out_req_rise: assert property ($rose(dma_out_req) |-> blk && age == (k256 ? `LAT256 : `LAT128))
    else $error("output request at wrong moment");
  a_in_req_drop: assert property (go |=> !dma_in_req [*2])
    else $error("input request stays after full block");
  a_irq_mask: assert property (acc && pwrite && paddr == `A_IEN && pwdata[2:0] == 3'h0 |=> !irq)
    else $error("interrupt not masked");
  a_irq_clear: assert property (acc && pwrite && paddr == `A_ICLR && pwdata[2:0] == 3'h7 && !blk |=> !irq)
    else $error("interrupt not cleared");
  a_dout_empty: assert property (acc && !pwrite && paddr == `A_DOUT && !blk |-> prdata == 32'h0 && !pslverr)
    else $error("empty output read not refused cleanly");
endmodule // aes_accel_sva

bind aes_block_cipher_accelerator aes_accel_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .irq(irq), .dma_in_req(dma_in_req), .dma_out_req(dma_out_req));
`default_nettype wire

// File: tb/aes_dma_model.sv
// DMA controller model feeding and draining the accelerator over APB
`timescale 1ns/1ns
`default_nettype none
`include "aes_accel_defines.vh"
module aes_dma_model (
  input  wire logic         pclk,
  input  wire logic         go,
  input  wire logic [3:0]   gap,
  input  wire logic         dma_in_req,
  input  wire logic         dma_out_req,
  input  wire logic         pready,
  input  wire logic [31:0]  prdata,
  input  wire logic [127:0] blk_in,
  output logic              psel,
  output logic              penable,
  output logic              pwrite,
  output logic [7:0]        paddr,
  output logic [31:0]       pwdata,
  output logic [127:0]      blk_out,
  output logic              done
);
  int ni;
  int no;
  assign done = (no == 4);

  task automatic xf(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    if (!w) blk_out[127-32*no -: 32] <= prdata;
    psel    <= 1'b0;
    penable <= 1'b0;
    // Released data lines must not keep the last word
    pwdata  <= ~d;
    repeat (gap + 1) @(posedge pclk);
  endtask

  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    blk_out = 128'h0;
    ni = 0;
    no = 0;
    forever begin
      @(posedge pclk);
      if (!go) begin
        ni = 0;
        no = 0;
      end else if (dma_in_req && ni < 4) begin
        xf(1'b1, `A_DIN, blk_in[127-32*ni -: 32]);
        ni++;
      end else if (dma_out_req && no < 4) begin
        xf(1'b0, `A_DOUT, 32'h0);
        no++;
      end
    end
  end
endmodule // aes_dma_model
`default_nettype wire

// File: tb/tb.sv
// Self-checking bench for the AES accelerator: APB tasks and block tests
`timescale 1ns/1ns
`default_nettype none
`include "aes_accel_defines.vh"
module tb;
  localparam logic [127:0] K128  = 128'h000102030405060708090A0B0C0D0E0F;
  localparam logic [255:0] K256  = {K128, 128'h101112131415161718191A1B1C1D1E1F};
  localparam logic [127:0] PT    = 128'h00112233445566778899AABBCCDDEEFF;
  localparam logic [127:0] CT128 = 128'h69C4E0D86A7B0430D8CDB78070B4C55A;
  localparam logic [127:0] CT256 = 128'h8EA2B7CA516745BFEAFC49904B496089;
  logic         pclk, presetn, go, slv, done;
  logic         c_psel, c_penable, c_pwrite, d_psel, d_penable, d_pwrite;
  logic         psel, penable, pwrite, pready, pslverr, irq, dma_in_req, dma_out_req;
  logic [7:0]   c_paddr, d_paddr, paddr;
  logic [31:0]  c_pwdata, d_pwdata, pwdata, prdata;
  logic [127:0] blk_out;
  int           err_count, samples_checked, m, s, i;
  // The DMA model owns the bus only while it runs
  assign psel    = go ? d_psel : c_psel;
  assign penable = go ? d_penable : c_penable;
  assign pwrite  = go ? d_pwrite : c_pwrite;
  assign paddr   = go ? d_paddr : c_paddr;
  assign pwdata  = go ? d_pwdata : c_pwdata;

  aes_block_cipher_accelerator dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .dma_in_req(dma_in_req),
    .dma_out_req(dma_out_req));
  aes_dma_model u_dma (.pclk(pclk), .go(go), .gap(4'h2), .dma_in_req(dma_in_req),
    .dma_out_req(dma_out_req), .pready(pready), .prdata(prdata), .blk_in(PT),
    .psel(d_psel), .penable(d_penable), .pwrite(d_pwrite), .paddr(d_paddr),
    .pwdata(d_pwdata), .blk_out(blk_out), .done(done));

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    c_psel    <= 1'b1;
    c_pwrite  <= w;
    c_paddr   <= a;
    c_pwdata  <= d;
    @(posedge pclk);
    c_penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    slv = pslverr;
    c_psel    <= 1'b0;
    c_penable <= 1'b0;
    c_pwdata  <= ~d;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic key(input logic [255:0] k, input int n);
    for (int j = 0; j < n; j++) wr(8'(`A_KEY0 + 4*j), k[255-32*j -: 32]);
  endtask

  task automatic put(input logic [127:0] d, input int k = 0);
    for (int j = 0; j < 4; j++) wr(`A_DIN, swp(d[127-32*j -: 32], k));
  endtask

  function automatic logic [31:0] swp(input logic [31:0] w, input int k);
    case (k)
      1: return {w[15:0], w[31:16]};
      2: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      3: return {<<{w}};
      default: return w;
    endcase
  endfunction

  task automatic get(input logic [127:0] e, input int k);
    logic [31:0] q;
    int          n;
    n = 0;
    do begin
      xfer(1'b0, `A_STAT, 32'h0, q);
      n++;
    end while (q[3] !== 1'b1 && n < 60);
    for (int j = 0; j < 4; j++) begin
      xfer(1'b0, `A_DOUT, 32'h0, q);
      chk(q, swp(e[127-32*j -: 32], k));
    end
  endtask

  task automatic finish_test;
    $display("Checked %0d values, %0d mismatches", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #2000000;
    err_count++;
    finish_test();
  end

  initial begin
    presetn = 1'b0;
    c_psel = 1'b0;
    c_penable = 1'b0;
    c_pwrite = 1'b0;
    c_paddr = 8'h00;
    c_pwdata = 32'h0;
    go = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(`A_CTRL, 32'h0);
    rd(`A_STAT, 32'h0);
    rd(`A_ISTAT, 32'h0);
    rd(8'h1C, 32'h0);
    chk({31'h0, slv}, 32'h1);
    $display("reset test done");
    wr(`A_CTRL, 32'h1);
    key({K128, 128'h0}, 4);
    rd(`A_KEY0, 32'h0);
    wr(`A_ICLR, 32'h7);
    wr(`A_IEN, 32'h1);
    put(PT);
    get(CT128, 0);
    chk({31'h0, irq}, 32'h1);
    wr(`A_IEN, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(`A_IEN, 32'h1);
    wr(`A_ICLR, 32'h1);
    chk({31'h0, irq}, 32'h0);
    $display("encrypt test done");
    wr(`A_CTRL, 32'h3);
    put(CT128);
    get(PT, 0);
    // A lone first key word must not replace the committed key
    wr(`A_KEY0, 32'hFFFFFFFF);
    wr(`A_CTRL, 32'h1);
    put(PT);
    get(CT128, 0);
    $display("decrypt test done");
    wr(`A_CTRL, 32'h81);
    key(K256, 8);
    wr(`A_ICLR, 32'h7);
    rd(`A_DOUT, 32'h0);
    put(PT);
    wr(`A_DIN, 32'h0);
    rd(`A_ISTAT, 32'h6);
    get(CT256, 0);
    $display("long key test done");
    wr(`A_CTRL, 32'h1);
    key({K128, 128'h0}, 4);
    for (m = 1; m < 6; m++) begin
      wr(`A_CTRL, 32'(m) << 2 | 32'h1);
      for (i = 0; i < 4; i++) wr(8'(`A_IV0 + 4*i), m == 1 ? 32'h0 : PT[127-32*i -: 32]);
      put(m == 1 ? PT : 128'h0);
      get(CT128, 0);
      rd(`A_IV3, m == 1 ? CT128[31:0] : PT[31:0] + 32'h1);
    end
    wr(`A_CTRL, 32'h7);
    for (i = 0; i < 4; i++) wr(8'(`A_IV0 + 4*i), 32'h0);
    put(CT128);
    get(PT, 0);
    rd(`A_IV3, CT128[31:0]);
    for (s = 0; s < 4; s++) begin
      // Pre-swapped input words, so the block seen inside is the plain text
      wr(`A_CTRL, 32'(s) << 5 | 32'h1);
      put(PT, s);
      get(CT128, s);
    end
    $display("mode test done");
    wr(`A_CTRL, 32'h301);
    go <= 1'b1;
    for (i = 0; i < 600 && done !== 1'b1; i++) @(posedge pclk);
    for (i = 0; i < 4; i++) chk(blk_out[127-32*i -: 32], CT128[127-32*i -: 32]);
    go <= 1'b0;
    @(posedge pclk);
    $display("dma test done");
    finish_test();
  end
endmodule // tb
`default_nettype wire
